// >>> clamp_gen.sv
`timescale 1ns/100ps
// Internal clamp window counted from the active hsync leading edge
module clamp_gen #(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  // Timing
  input  wire logic          hs_lead_i,
  input  wire logic [CW-1:0] place_i,
  input  wire logic [CW-1:0] dur_i,
  // Result
  output logic               clamp_o
);

  // Refuse widths the window arithmetic cannot serve
  if (CW < 1 || CW > 16) begin : g_cw_check
    $error("clamp_gen: CW out of range");
  end

  logic [CW:0] cnt_q;
  logic        run_q;

  // Count from each leading edge; a new edge restarts the window
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (hs_lead_i) begin
      cnt_q <= '0;
      run_q <= 1'b1;
    end else if (run_q) begin
      cnt_q <= cnt_q + 1'b1;
      if (cnt_q == ({1'b0, place_i} + {1'b0, dur_i})) run_q <= 1'b0;
    end
  end

  // Active from placement for duration cycles
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) clamp_o <= 1'b0;
    else clamp_o <= run_q && !hs_lead_i && (dur_i != '0)
                    && (cnt_q >= {1'b0, place_i})
                    && (cnt_q < ({1'b0, place_i} + {1'b0, dur_i}));
  end

endmodule

// >>> pin_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser for a group of pins
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_b_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // An empty group would leave the output undriven
  if (W < 1) begin : g_w_check
    $error("pin_sync: W must be positive");
  end

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

// >>> sync_clamp_coast_control.sv
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
module sync_clamp_coast_control #(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  // Register port
  input  wire logic [7:0]    addr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [7:0]    rdata_o,
  // Sync pins and internal sources
  input  wire logic          vsync_pin_i,
  input  wire logic          coast_pin_i,
  input  wire logic          clamp_pin_i,
  input  wire logic          green_embedded_sync_in_i,
  input  wire logic          sep_vsync_i,
  input  wire logic          hs_lead_i,
  input  wire logic          vs_active_i,
  input  wire logic          coast_pol_det_i,
  input  wire logic [CW-1:0] clamp_place_i,
  input  wire logic [CW-1:0] clamp_dur_i,
  // Steering outputs
  output logic               vsync_o,
  output logic               active_vertical_sync_status_o,
  output logic               clamp_o,
  output logic [2:0]         clamp_mid_o,
  output logic               coast_o,
  output logic               seek_mode_o,
  output logic               full_power_down_n_o,
  output logic [4:0]         slicer_code_o
);

  // Refuse clamp counter widths the window arithmetic cannot serve
  if (CW < 1 || CW > 16) begin : g_cw_check
    $error("CW out of range");
  end

  // All checks below sample on the system clock and pause in reset
  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);

  // ****************************************************
  // Register file
  // ****************************************************
  sync_ctrl_pkg::reg_req_t req;
  assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  logic [7:0] mode_q;
  logic [7:0] coast_q;
  logic [7:0] slicer_q;

  // Writes only; fields hold otherwise
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q   <= sync_ctrl_pkg::RST_SYNC_MODE;
      coast_q  <= sync_ctrl_pkg::RST_CLAMP_COAST;
      slicer_q <= sync_ctrl_pkg::RST_SLICER_CLAMP;
    end else if (req.wr) begin
      unique case (req.addr)
        sync_ctrl_pkg::ADDR_SYNC_MODE:    mode_q   <= req.wdata;
        sync_ctrl_pkg::ADDR_CLAMP_COAST:  coast_q  <= req.wdata;
        sync_ctrl_pkg::ADDR_SLICER_CLAMP: slicer_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // Read data one cycle later; unmapped reads zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) rdata_o <= 8'h00;
    else if (req.rd) begin
      unique case (req.addr)
        sync_ctrl_pkg::ADDR_SYNC_MODE:    rdata_o <= mode_q;
        sync_ctrl_pkg::ADDR_CLAMP_COAST:  rdata_o <= coast_q;
        sync_ctrl_pkg::ADDR_SLICER_CLAMP: rdata_o <= slicer_q;
        default:                          rdata_o <= 8'h00;
      endcase
    end else rdata_o <= 8'h00;
  end

  // Decoded fields
  sync_ctrl_pkg::ctrl_fields_t f;
  always_comb begin
    f.vs_invert_n  = mode_q[sync_ctrl_pkg::VS_INVERT_BIT];
    f.vs_override  = mode_q[sync_ctrl_pkg::VS_OVERRIDE_BIT];
    f.vs_select    = mode_q[sync_ctrl_pkg::VS_SELECT_BIT];
    f.clamp_ext    = coast_q[sync_ctrl_pkg::CLAMP_EXT_BIT];
    f.clamp_pol    = coast_q[sync_ctrl_pkg::CLAMP_POL_BIT];
    f.coast_vsync  = coast_q[sync_ctrl_pkg::COAST_VSYNC_BIT];
    f.coast_ovr    = coast_q[sync_ctrl_pkg::COAST_OVR_BIT];
    f.coast_pol    = coast_q[sync_ctrl_pkg::COAST_POL_BIT];
    f.seek_allow   = coast_q[sync_ctrl_pkg::SEEK_ALLOW_BIT];
    f.power_down_n = coast_q[sync_ctrl_pkg::POWER_DOWN_N_BIT];
    f.slicer_code  = slicer_q[7:sync_ctrl_pkg::SLICER_LSB];
    f.clamp_mid    = slicer_q[2:0];
  end

  // ****************************************************
  // Pin synchronisers
  // ****************************************************
  logic [3:0] pins_s;
  pin_sync #(.W(4)) u_pins (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .d_i       ({vsync_pin_i, coast_pin_i, clamp_pin_i,
                 green_embedded_sync_in_i}),
    .q_o       (pins_s)
  );
  logic vs_pin_s;
  logic coast_pin_s;
  logic clamp_pin_s;
  logic sog_s;
  assign {vs_pin_s, coast_pin_s, clamp_pin_s, sog_s} = pins_s;

  // ****************************************************
  // Vsync source and coast
  // ****************************************************
  // Automatic choice prefers the pin while it shows activity
  logic active_vertical_sync_status;
  assign active_vertical_sync_status = f.vs_override ? f.vs_select
                             : !vs_active_i;
  logic vs_src;
  assign vs_src = active_vertical_sync_status ? sep_vsync_i : vs_pin_s;

  // Coast source then polarity; active level compared to high
  logic coast_raw;
  logic coast_hi;
  assign coast_raw = f.coast_vsync ? vs_src : coast_pin_s;
  assign coast_hi  = f.coast_ovr ? f.coast_pol
                                 : coast_pol_det_i;

  // Sync outputs registered
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vsync_o                       <= 1'b0;
      active_vertical_sync_status_o <= 1'b0;
      coast_o                       <= 1'b0;
    end else begin
      vsync_o                       <= vs_src ^ !f.vs_invert_n;
      active_vertical_sync_status_o <= active_vertical_sync_status;
      coast_o <= coast_hi ? coast_raw : !coast_raw;
    end
  end

  // ****************************************************
  // Clamp
  // ****************************************************
  logic clamp_int;
  clamp_gen #(.CW(CW)) u_clamp (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .hs_lead_i (hs_lead_i),
    .place_i   (clamp_place_i),
    .dur_i     (clamp_dur_i),
    .clamp_o   (clamp_int)
  );

  // External clamp: polarity 1 means clamp on low level
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) clamp_o <= 1'b0;
    else if (f.clamp_ext) clamp_o <= clamp_pin_s ^ f.clamp_pol;
    else clamp_o <= clamp_int;
  end

  // ****************************************************
  // Power, seek, slicer and clamp reference
  // ****************************************************
  // Seek only with no vsync or green sync activity; green activity is
  // approximated by the synchronised level, a detector sits elsewhere
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seek_mode_o         <= 1'b0;
      full_power_down_n_o <= 1'b1;
      slicer_code_o       <= sync_ctrl_pkg::RST_SLICER_CODE;
      clamp_mid_o         <= 3'b000;
    end else begin
      seek_mode_o         <= f.seek_allow && !vs_active_i && !sog_s;
      full_power_down_n_o <= f.power_down_n;
      slicer_code_o       <= f.slicer_code;
      clamp_mid_o         <= f.clamp_mid;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  // A strobe aimed at one register, and the edge after it at which
  // the stored value has reached the decoded fields
  sequence s_reg_write(logic [7:0] a);
    wr_i && !rd_i && addr_i == a;
  endsequence

  sequence s_write_settled(logic [7:0] a);
    s_reg_write(a) ##1 1'b1;
  endsequence

  // Vsync polarity; the first edge after reset is skipped because
  // the output flop still shows its reset value there
  a_vs_invert: assert property ($past(rst_b_i) |->
    vsync_o == ($past(vs_src) ^ !$past(f.vs_invert_n)))
    else $error("vsync output polarity wrong");
  a_vs_source: assert property (f.vs_override |=>
    vsync_o == (!$past(f.vs_invert_n) ^ ($past(f.vs_select)
                ? $past(sep_vsync_i) : $past(vs_pin_s))))
    else $error("vsync source under override wrong");

  // Source reported as active, under override and automatic
  a_avs_status: assert property (f.vs_override |=>
    active_vertical_sync_status_o == $past(f.vs_select))
    else $error("override status mismatch");
  a_avs_override: assert property (
    s_write_settled(sync_ctrl_pkg::ADDR_SYNC_MODE) ##0 f.vs_override
    |=> active_vertical_sync_status_o == $past(f.vs_select))
    else $error("override written but not applied");
  a_avs_auto_pin: assert property (!f.vs_override && vs_active_i |=>
    !active_vertical_sync_status_o)
    else $error("auto vsync source not the pin");
  a_avs_auto_sep: assert property (!f.vs_override && !vs_active_i |=>
    active_vertical_sync_status_o)
    else $error("auto vsync source not the separator");

  // Clamp source, window restart and external polarity
  a_clamp_int: assert property (!f.clamp_ext |=>
    clamp_o == $past(clamp_int))
    else $error("internal clamp not used");
  a_clamp_restart: assert property (hs_lead_i |=> !clamp_int)
    else $error("clamp window not restarted by hsync");
  a_clamp_ext: assert property (f.clamp_ext && f.clamp_pol |=>
    clamp_o == !$past(clamp_pin_s))
    else $error("external clamp active-low level wrong");
  a_clamp_ext_hi: assert property (f.clamp_ext && !f.clamp_pol |=>
    clamp_o == $past(clamp_pin_s))
    else $error("external clamp active-high level wrong");

  // Coast source, then the polarity that sets its active level
  a_coast_vsync: assert property (f.coast_vsync |=>
    coast_o == ($past(vs_src) ~^ $past(coast_hi)))
    else $error("coast not taken from active vsync");
  a_coast_pin: assert property (!f.coast_vsync |=>
    coast_o == ($past(coast_pin_s) ~^ $past(coast_hi)))
    else $error("coast not taken from its pin");
  a_coast_det: assert property (!f.coast_ovr |=>
    coast_o == ($past(coast_raw) ~^ $past(coast_pol_det_i)))
    else $error("detected coast polarity ignored");
  a_coast_user: assert property (f.coast_ovr |=>
    coast_o == ($past(coast_raw) ~^ $past(f.coast_pol)))
    else $error("user coast polarity ignored");

  // Seek and power-down follow their bits one edge after the store
  a_seek_block: assert property (!f.seek_allow |=> !seek_mode_o)
    else $error("seek entered while forbidden");
  a_seek_enter: assert property (
    f.seek_allow && !vs_active_i && !sog_s |=> seek_mode_o)
    else $error("seek not entered with no sync activity");
  a_power_down: assert property (
    s_write_settled(sync_ctrl_pkg::ADDR_CLAMP_COAST)
    |=> full_power_down_n_o == $past(f.power_down_n))
    else $error("power down not following bit");

  // Slicer code and clamp references mirror their fields
  a_slicer_code: assert property (
    slicer_code_o == $past(f.slicer_code))
    else $error("slicer code not following field");
  a_clamp_ref: assert property (clamp_mid_o == $past(f.clamp_mid))
    else $error("clamp reference not following field");

  // Stored fields move only on a write strobe; reads return them
  a_fields_hold: assert property (!wr_i |=>
    $stable(mode_q) && $stable(coast_q) && $stable(slicer_q))
    else $error("register changed without a write");
  a_fields_write: assert property (
    s_reg_write(sync_ctrl_pkg::ADDR_SYNC_MODE) |=> mode_q == $past(wdata_i))
    else $error("written value not stored");
  a_read_back: assert property (
    rd_i && !wr_i && addr_i == sync_ctrl_pkg::ADDR_SLICER_CLAMP
    |=> rdata_o == $past(slicer_q))
    else $error("read data mismatch");

endmodule

// >>> sync_clamp_coast_control_tb_top.sv
`timescale 1ns/100ps
module sync_clamp_coast_control_tb_top;
  // ********
  // Stimulus and observed signals
  // ********
  typedef struct packed {
    logic [7:0] r0e;
    logic [7:0] r0f;
    logic [7:0] r10;
    logic [6:0] pins;
    logic [5:0] outs;
  } row_t;

  logic       clk_sys_i = 1'b0;
  logic       rst_b_i   = 1'b0;
  logic [7:0] addr_i    = 8'h00;
  logic [7:0] wdata_i   = 8'h00;
  logic       wr_i      = 1'b0;
  logic       rd_i      = 1'b0;
  logic [6:0] pins      = 7'h00;
  logic       hs_lead_i = 1'b0;
  logic [7:0] place     = 8'h00;
  logic [7:0] dur       = 8'h00;
  logic [7:0] rdata_o;
  logic       vsync_o;
  logic       avs_o;
  logic       clamp_o;
  logic       coast_o;
  logic       seek_o;
  logic       pdn_o;
  logic [2:0] mid_o;
  logic [4:0] slicer_o;
  int         failures        = 0;
  int         samples_checked = 0;
  int         hits;
  logic [7:0] durs [3] = '{8'h05, 8'h00, 8'h01};

  // Pins {vs, coast, clamp, green, sep, vs_act, pol_det}
  // Outs {vsync, status, clamp, coast, seek, power_n}
  row_t rows [8] = '{
    '{8'h00, 8'h4e, 8'hb8, 7'b1100011, 6'b000101},
    '{8'h00, 8'h4e, 8'h01, 7'b1000000, 6'b110111},
    '{8'h04, 8'h4e, 8'h04, 7'b0001101, 6'b110001},
    '{8'h06, 8'hc0, 8'h02, 7'b1100001, 6'b101100},
    '{8'h07, 8'h80, 8'hfd, 7'b1000010, 6'b010100},
    '{8'h07, 8'h98, 8'h07, 7'b0010100, 6'b111000},
    '{8'h03, 8'h36, 8'h92, 7'b1110001, 6'b110111},
    '{8'h02, 8'h3e, 8'h53, 7'b1001010, 6'b000101}
  };

  // 40 MHz system clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  sync_clamp_coast_control #(.CW(8)) sync_clamp_coast_control_inst (
    .clk_sys_i                     (clk_sys_i),
    .rst_b_i                       (rst_b_i),
    .addr_i                        (addr_i),
    .wdata_i                       (wdata_i),
    .wr_i                          (wr_i),
    .rd_i                          (rd_i),
    .rdata_o                       (rdata_o),
    .vsync_pin_i                   (pins[6]),
    .coast_pin_i                   (pins[5]),
    .clamp_pin_i                   (pins[4]),
    .green_embedded_sync_in_i      (pins[3]),
    .sep_vsync_i                   (pins[2]),
    .hs_lead_i                     (hs_lead_i),
    .vs_active_i                   (pins[1]),
    .coast_pol_det_i               (pins[0]),
    .clamp_place_i                 (place),
    .clamp_dur_i                   (dur),
    .vsync_o                       (vsync_o),
    .active_vertical_sync_status_o (avs_o),
    .clamp_o                       (clamp_o),
    .clamp_mid_o                   (mid_o),
    .coast_o                       (coast_o),
    .seek_mode_o                   (seek_o),
    .full_power_down_n_o           (pdn_o),
    .slicer_code_o                 (slicer_o)
  );

  // ********
  // Shared tasks
  // ********
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Bus tasks wait an edge first so a strobe is never set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, want);
  endtask

  // Pins pass two sync flops, so allow a few edges to settle
  task automatic outs(input row_t r);
    repeat (5) @(posedge clk_sys_i);
    #1;
    check({2'b00, vsync_o, avs_o, clamp_o, coast_o, seek_o, pdn_o},
          {2'b00, r.outs});
    check({3'b000, slicer_o}, {3'b000, r.r10[7:3]});
    check({5'b00000, mid_o}, {5'b00000, r.r10[2:0]});
  endtask

  // Reset held two edges, outputs checked while held, released at an edge
  task automatic reset_check;
    rst_b_i <= 1'b0;
    @(posedge clk_sys_i);
    #1;
    check({2'b00, vsync_o, avs_o, clamp_o, coast_o, seek_o, pdn_o},
          8'h01);
    check({3'b000, slicer_o}, 8'h17);
    check({5'b00000, mid_o}, 8'h00);
    check(rdata_o, 8'h00);
    @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(sync_ctrl_pkg::ADDR_SYNC_MODE, 8'h00);
    rd(sync_ctrl_pkg::ADDR_CLAMP_COAST, 8'h4e);
    rd(sync_ctrl_pkg::ADDR_SLICER_CLAMP, 8'hb8);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ********
  // Main sequence
  // ********
  initial begin
    reset_check();
    foreach (rows[i]) begin
      wr(sync_ctrl_pkg::ADDR_SYNC_MODE, rows[i].r0e);
      wr(sync_ctrl_pkg::ADDR_CLAMP_COAST, rows[i].r0f);
      wr(sync_ctrl_pkg::ADDR_SLICER_CLAMP, rows[i].r10);
      pins <= rows[i].pins;
      outs(rows[i]);
      rd(sync_ctrl_pkg::ADDR_SYNC_MODE, rows[i].r0e);
      rd(sync_ctrl_pkg::ADDR_CLAMP_COAST, rows[i].r0f);
      rd(sync_ctrl_pkg::ADDR_SLICER_CLAMP, rows[i].r10);
    end
    // Unmapped places neither store nor disturb the real registers
    wr(8'h0d, 8'hff);
    wr(8'h11, 8'hff);
    rd(8'h11, 8'h00);
    rd(8'hff, 8'h00);
    rd(sync_ctrl_pkg::ADDR_CLAMP_COAST, 8'h3e);
    @(posedge clk_sys_i);
    #1;
    check(rdata_o, 8'h00);
    // Write then read with no gap; power output lags one edge
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= sync_ctrl_pkg::ADDR_CLAMP_COAST;
    wdata_i <= 8'h3c;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    #1;
    check({7'h00, pdn_o}, 8'h01);
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, 8'h3c);
    check({7'h00, pdn_o}, 8'h00);
    // External clamp pin reaches the output on the third edge
    wr(sync_ctrl_pkg::ADDR_CLAMP_COAST, 8'h80);
    repeat (4) @(posedge clk_sys_i);
    pins[4] <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({7'h00, clamp_o}, 8'h00);
    @(posedge clk_sys_i);
    #1;
    check({7'h00, clamp_o}, 8'h01);
    // Internal window length follows the duration, zero included
    wr(sync_ctrl_pkg::ADDR_CLAMP_COAST, 8'h4e);
    foreach (durs[k]) begin
      @(posedge clk_sys_i);
      dur       <= durs[k];
      place     <= 8'h03;
      hs_lead_i <= 1'b1;
      @(posedge clk_sys_i);
      hs_lead_i <= 1'b0;
      hits = 0;
      repeat (40) begin
        @(posedge clk_sys_i);
        #1;
        if (clamp_o === 1'b1) begin
          hits++;
        end
      end
      check(8'(hits), durs[k]);
    end
    // Second reset in mid-run restores every default
    @(posedge clk_sys_i);
    reset_check();
    tally_and_finish();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    tally_and_finish();
  end
endmodule

// >>> sync_ctrl_pkg.sv
package sync_ctrl_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [7:0] ADDR_SYNC_MODE    = 8'h0e;
  localparam logic [7:0] ADDR_CLAMP_COAST  = 8'h0f;
  localparam logic [7:0] ADDR_SLICER_CLAMP = 8'h10;

  // Field positions in sync_mode_control
  localparam int VS_INVERT_BIT   = 2;
  localparam int VS_OVERRIDE_BIT = 1;
  localparam int VS_SELECT_BIT   = 0;

  // Field positions in clamp_coast_power_control
  localparam int CLAMP_EXT_BIT     = 7;
  localparam int CLAMP_POL_BIT     = 6;
  localparam int COAST_VSYNC_BIT   = 5;
  localparam int COAST_OVR_BIT     = 4;
  localparam int COAST_POL_BIT     = 3;
  localparam int SEEK_ALLOW_BIT    = 2;
  localparam int POWER_DOWN_N_BIT  = 1;

  // Field positions in slicer_clamp_reference_control
  localparam int SLICER_LSB    = 3;
  localparam int RED_MID_BIT   = 2;
  localparam int GREEN_MID_BIT = 1;
  localparam int BLUE_MID_BIT  = 0;

  // Power-up values; unlisted bits reset to zero
  localparam logic [7:0] RST_SYNC_MODE    = 8'h00;
  localparam logic [7:0] RST_CLAMP_COAST  = 8'h4e;
  localparam logic [4:0] RST_SLICER_CODE  = 5'h17;
  localparam logic [7:0] RST_SLICER_CLAMP = {RST_SLICER_CODE, 3'b000};

  // Control fields handed to the sync, clamp and coast logic
  typedef struct packed {
    logic       vs_invert_n;
    logic       vs_override;
    logic       vs_select;
    logic       clamp_ext;
    logic       clamp_pol;
    logic       coast_vsync;
    logic       coast_ovr;
    logic       coast_pol;
    logic       seek_allow;
    logic       power_down_n;
    logic [4:0] slicer_code;
    logic [2:0] clamp_mid;
  } ctrl_fields_t;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage
